// File: core/rakl_consts.svh
`ifndef RAKL_CONSTS_SVH
`define RAKL_CONSTS_SVH

// ----------------------------------------------------------------------
// Line characters (seven-bit codes)
// ----------------------------------------------------------------------
`define RAKL_CH_SOR 7'h3B
`define RAKL_CH_CR 7'h0D
`define RAKL_CH_0 7'h30
`define RAKL_CH_9 7'h39
`define RAKL_CH_A 7'h41
`define RAKL_CH_F 7'h46
`define RAKL_CH_LA 7'h61
`define RAKL_CH_LF 7'h66
`define RAKL_HEX_ALPHA 4'hA

// ----------------------------------------------------------------------
// Answer codes
// ----------------------------------------------------------------------
`define RAKL_ACK 8'h2A
`define RAKL_NAK_ANY 8'h55
`define RAKL_NAK_COUNT 8'h30
`define RAKL_NAK_TIMEOUT 8'h54
`define RAKL_NAK_ADDR 8'h41
`define RAKL_NAK_SUM 8'h43
`define RAKL_NAK_LEN 8'h4C
`define RAKL_NO_ERR 8'h00

// ----------------------------------------------------------------------
// Record layout
// ----------------------------------------------------------------------
`define RAKL_HDR_DIGITS 7'd8
`define RAKL_SUM_DIGITS 7'd4
`define RAKL_MAX_BYTES 8'd32
`define RAKL_FIXED_CHARS 10'd14

// ----------------------------------------------------------------------
// Timing: a tick of 1/15 s, sized for the slowest line rate
// ----------------------------------------------------------------------
`define RAKL_TICK_HZ 15
`define RAKL_MIN_BAUD 75
`define RAKL_CHAR_BITS 10
`define RAKL_GRACE_SEC 1
`define RAKL_NEXT_SEC 15
`define RAKL_TICKS_PER_CHAR \
    ((`RAKL_CHAR_BITS * `RAKL_TICK_HZ + `RAKL_MIN_BAUD - 1) / `RAKL_MIN_BAUD)
`define RAKL_GRACE_TICKS (`RAKL_GRACE_SEC * `RAKL_TICK_HZ)
`define RAKL_NEXT_TICKS (`RAKL_NEXT_SEC * `RAKL_TICK_HZ)

`endif

// File: core/rakl_pkg.sv
`include "rakl_consts.svh"

package rakl_pkg;

    typedef enum logic [3:0] {
        RAKL_IDLE = 4'h0,
        RAKL_HDR = 4'h1,
        RAKL_DATA = 4'h2,
        RAKL_SUM = 4'h3,
        RAKL_WAIT_CR = 4'h4,
        RAKL_SEND = 4'h5,
        RAKL_NEXT = 4'h6,
        RAKL_DEAD = 4'h7
    } rakl_state_t;

    // Returns {is_hex, value}
    function automatic logic [4:0] rakl_hex(input logic [6:0] c);
        logic [4:0] r;
        r = 5'h00;
        if (c >= `RAKL_CH_0 && c <= `RAKL_CH_9)
        begin
            r = {1'b1, c[3:0]};
        end
        else if (c >= `RAKL_CH_A && c <= `RAKL_CH_F)
        begin
            r = {1'b1, 4'(c - `RAKL_CH_A) + `RAKL_HEX_ALPHA};
        end
        else if (c >= `RAKL_CH_LA && c <= `RAKL_CH_LF)
        begin
            r = {1'b1, 4'(c - `RAKL_CH_LA) + `RAKL_HEX_ALPHA};
        end
        return r;
    endfunction : rakl_hex

endpackage : rakl_pkg

// File: core/rakl_receiver.sv
// Function
// (RULE1) Whole record received correctly is answered with asterisk 2A.
// (RULE2) Sender treats any answer other than asterisk as negative.
// (RULE3) Sender repeats last record after each negative answer, no limit.
// (RULE4) Transfer is data records then one end record, each answered.
// (RULE5) Sender sends record characters back to back.
// (RULE6) Text before first record has no semicolon, ends with CR LF.
// (RULE7) Reception error is answered with U or a class-specific code.
// (RULE8) End record count mismatch is answered with the count code only.
// (RULE9) Sender retries on all negative codes except the count code.
// (RULE10) Answer within one second of CR, never before the CR.
// (RULE11) Record end is recognised only by the carriage return.
// (RULE12) Record timeout sized from byte count; negative code when CR late.
// (RULE13) Wait 15 s for next semicolon, then send unsolicited timeout code.
// (RULE14) Second consecutive next-record timeout: line dead, stop, alert.
// (RULE15) Sender flushes pending input before sending closing CR.
// (RULE16) Sender times out seven seconds after its CR without answer.
// (RULE17) Sender declares line dead on second answer timeout.
// (RULE18) Works and keeps valid timeouts from 75 to 600 baud.
// (RULE19) Record: semicolon, count, address, address sum, data, sum, CR.
// (RULE20) End record has zero count, address field holds record total.
// (RULE21) No data stored before the address checksum is verified.
// (RULE22) Only the seven low bits of each character are used.
// (RULE23) Timeouts count ticks from a prescaler of the local clock.
`timescale 1ns/1ns
`include "rakl_consts.svh"

module rakl_receiver #(
    parameter int CLK_HZ = 50000000,
    parameter int TICK_CYCLES = CLK_HZ / `RAKL_TICK_HZ
) (
    input wire logic clk,
    input wire logic rstn,
    input wire logic [7:0] rx_char,
    input wire logic rx_valid,
    input wire logic addr_check_ok,
    input wire logic rec_check_ok,
    input wire logic tx_ready,
    output logic [7:0] tx_char,
    output logic tx_valid,
    output logic mem_we,
    output logic [15:0] mem_addr,
    output logic [7:0] mem_data,
    output logic [7:0] record_byte_count,
    output logic [15:0] record_start_address,
    output logic [7:0] address_checksum,
    output logic [15:0] record_checksum,
    output logic [15:0] record_total,
    output logic [7:0] last_nak,
    output logic transfer_done,
    output logic line_dead,
    output logic operator_alert
);

    generate
        if (TICK_CYCLES < 1)
        begin : g_bad
            $error("rakl_receiver: TICK_CYCLES must be at least 1");
        end
    endgenerate

    // ------------------------------------------------------------------
    // Tick source
    // ------------------------------------------------------------------
    logic tick;

    rakl_tick #(
        .TICK_CYCLES(TICK_CYCLES)
    ) u_tick (
        .clk(clk),
        .rstn(rstn),
        .tick(tick) // RULE23
    );

    // ------------------------------------------------------------------
    // State
    // ------------------------------------------------------------------
    rakl_pkg::rakl_state_t state, next_state;
    rakl_pkg::rakl_state_t after, next_after;
    logic [6:0] dig_cnt, next_dig_cnt;
    logic [31:0] hdr, next_hdr;
    logic [15:0] sum_field, next_sum_field;
    logic [3:0] byte_hi, next_byte_hi;
    logic [7:0] byte_idx, next_byte_idx;
    logic addr_pending, next_addr_pending;
    logic addr_ok, next_addr_ok;
    logic [7:0] err, next_err;
    logic [15:0] rec_count, next_rec_count;
    logic [9:0] tmo, next_tmo;
    logic miss, next_miss;
    logic [7:0] next_tx_char;
    logic next_tx_valid;
    logic next_mem_we;
    logic [15:0] next_mem_addr;
    logic [7:0] next_mem_data;
    logic [7:0] next_last_nak;
    logic next_done;
    logic next_alert;

    logic [6:0] ch;
    logic [4:0] hx;
    logic [7:0] jj;
    logic [7:0] jj_lim;
    logic [9:0] rec_limit;
    logic [7:0] answer;
    logic in_record;

    assign ch = rx_char[6:0]; // RULE22
    assign hx = rakl_pkg::rakl_hex(ch);
    assign jj = hdr[31:24];
    assign in_record = (state == rakl_pkg::RAKL_HDR)
        || (state == rakl_pkg::RAKL_DATA)
        || (state == rakl_pkg::RAKL_SUM)
        || (state == rakl_pkg::RAKL_WAIT_CR);

    // Until the count is known, assume the longest record
    always_comb
    begin
        if (state == rakl_pkg::RAKL_HDR || jj > `RAKL_MAX_BYTES)
        begin
            jj_lim = `RAKL_MAX_BYTES;
        end
        else
        begin
            jj_lim = jj;
        end
    end

    // Due time of the CR at the slowest rate, plus one second
    assign rec_limit = 10'(`RAKL_TICKS_PER_CHAR)
        * (`RAKL_FIXED_CHARS + {1'b0, jj_lim, 1'b0})
        + 10'(`RAKL_GRACE_TICKS); // RULE12 RULE18

    // Answer chosen at the CR; the first error seen wins
    always_comb
    begin
        if (state != rakl_pkg::RAKL_WAIT_CR && err == `RAKL_NO_ERR)
        begin
            answer = `RAKL_NAK_LEN;
        end
        else if (err != `RAKL_NO_ERR)
        begin
            answer = err; // RULE7
        end
        else if (!rec_check_ok)
        begin
            answer = `RAKL_NAK_SUM; // RULE7
        end
        else if (jj == 8'h00 && record_start_address != rec_count)
        begin
            answer = `RAKL_NAK_COUNT; // RULE8 RULE20
        end
        else
        begin
            answer = `RAKL_ACK; // RULE1
        end
    end

    // ------------------------------------------------------------------
    // Next-state logic
    // ------------------------------------------------------------------
    always_comb
    begin
        next_state = state;
        next_after = after;
        next_dig_cnt = dig_cnt;
        next_hdr = hdr;
        next_sum_field = sum_field;
        next_byte_hi = byte_hi;
        next_byte_idx = byte_idx;
        next_addr_pending = 1'b0;
        next_addr_ok = addr_ok;
        next_err = err;
        next_rec_count = rec_count;
        next_tmo = tick ? tmo + 10'h001 : tmo;
        next_miss = miss;
        next_tx_char = tx_char;
        next_tx_valid = tx_valid;
        next_mem_we = 1'b0;
        next_mem_addr = mem_addr;
        next_mem_data = mem_data;
        next_last_nak = last_nak;
        next_done = 1'b0;
        next_alert = 1'b0;

        // Verdict on the address checksum, one cycle after its last digit
        if (addr_pending)
        begin
            next_addr_ok = addr_check_ok; // RULE21
            if (!addr_check_ok && err == `RAKL_NO_ERR)
            begin
                next_err = `RAKL_NAK_ADDR;
            end
        end

        if (in_record && rx_valid && ch == `RAKL_CH_CR)
        begin
            // The CR alone closes a record; errors wait for it
            next_tx_char = answer; // RULE10 RULE11
            next_tx_valid = 1'b1;
            next_state = rakl_pkg::RAKL_SEND;
            next_after = rakl_pkg::RAKL_NEXT;
            if (answer != `RAKL_ACK)
            begin
                next_last_nak = answer;
            end
            else if (jj == 8'h00)
            begin
                next_after = rakl_pkg::RAKL_IDLE; // RULE4
            end
            else
            begin
                next_rec_count = rec_count + 16'h0001; // RULE20
            end
        end
        else if (in_record && tick && next_tmo >= rec_limit)
        begin
            next_tx_char = `RAKL_NAK_TIMEOUT; // RULE12
            next_tx_valid = 1'b1;
            next_last_nak = `RAKL_NAK_TIMEOUT;
            next_state = rakl_pkg::RAKL_SEND;
            next_after = rakl_pkg::RAKL_NEXT;
        end
        else
        begin
            case (state)
                rakl_pkg::RAKL_IDLE, rakl_pkg::RAKL_NEXT:
                begin
                    if (rx_valid && ch == `RAKL_CH_SOR)
                    begin
                        // Other text, CR and LF between records is ignored
                        next_state = rakl_pkg::RAKL_HDR; // RULE6 RULE19
                        next_dig_cnt = 7'h00;
                        next_hdr = 32'h0;
                        next_err = `RAKL_NO_ERR;
                        next_addr_ok = 1'b0;
                        next_byte_idx = 8'h00;
                        next_tmo = 10'h000;
                        next_miss = 1'b0;
                    end
                    else if (state == rakl_pkg::RAKL_IDLE)
                    begin
                        next_tmo = 10'h000;
                    end
                    else if (tick && next_tmo > 10'(`RAKL_NEXT_TICKS))
                    begin
                        next_tmo = 10'h000;
                        next_last_nak = `RAKL_NAK_TIMEOUT;
                        if (miss)
                        begin
                            next_state = rakl_pkg::RAKL_DEAD; // RULE14
                            next_alert = 1'b1;
                        end
                        else
                        begin
                            next_miss = 1'b1;
                            next_tx_char = `RAKL_NAK_TIMEOUT; // RULE13
                            next_tx_valid = 1'b1;
                            next_state = rakl_pkg::RAKL_SEND;
                            next_after = rakl_pkg::RAKL_NEXT;
                        end
                    end
                end
                rakl_pkg::RAKL_HDR:
                begin
                    if (rx_valid)
                    begin
                        if (!hx[4] && err == `RAKL_NO_ERR)
                        begin
                            next_err = `RAKL_NAK_ANY;
                        end
                        next_hdr = {hdr[27:0], hx[3:0]};
                        next_dig_cnt = dig_cnt + 7'h01;
                        if (next_dig_cnt == `RAKL_HDR_DIGITS)
                        begin
                            next_addr_pending = 1'b1;
                            next_dig_cnt = 7'h00;
                            if (next_hdr[31:24] == 8'h00)
                            begin
                                next_state = rakl_pkg::RAKL_SUM;
                            end
                            else if (next_hdr[31:24] > `RAKL_MAX_BYTES)
                            begin
                                next_err = (next_err == `RAKL_NO_ERR)
                                    ? `RAKL_NAK_LEN : next_err;
                                next_state = rakl_pkg::RAKL_WAIT_CR;
                            end
                            else
                            begin
                                next_state = rakl_pkg::RAKL_DATA;
                            end
                        end
                    end
                end
                rakl_pkg::RAKL_DATA:
                begin
                    if (rx_valid)
                    begin
                        if (!hx[4] && err == `RAKL_NO_ERR)
                        begin
                            next_err = `RAKL_NAK_ANY;
                        end
                        if (!dig_cnt[0])
                        begin
                            next_byte_hi = hx[3:0];
                        end
                        else
                        begin
                            // Storage only behind a verified address sum
                            next_mem_we = addr_ok; // RULE21
                            next_mem_addr = record_start_address
                                + {8'h00, byte_idx};
                            next_mem_data = {byte_hi, hx[3:0]};
                            next_byte_idx = byte_idx + 8'h01;
                        end
                        next_dig_cnt = dig_cnt + 7'h01;
                        if ({1'b0, next_dig_cnt} == {jj[6:0], 1'b0})
                        begin
                            next_dig_cnt = 7'h00;
                            next_state = rakl_pkg::RAKL_SUM;
                        end
                    end
                end
                rakl_pkg::RAKL_SUM:
                begin
                    if (rx_valid)
                    begin
                        if (!hx[4] && err == `RAKL_NO_ERR)
                        begin
                            next_err = `RAKL_NAK_ANY;
                        end
                        next_sum_field = {sum_field[11:0], hx[3:0]};
                        next_dig_cnt = dig_cnt + 7'h01;
                        if (next_dig_cnt == `RAKL_SUM_DIGITS)
                        begin
                            next_state = rakl_pkg::RAKL_WAIT_CR;
                        end
                    end
                end
                rakl_pkg::RAKL_WAIT_CR:
                begin
                    if (rx_valid && err == `RAKL_NO_ERR)
                    begin
                        next_err = `RAKL_NAK_LEN;
                    end
                end
                rakl_pkg::RAKL_SEND:
                begin
                    next_tmo = 10'h000;
                    if (tx_ready)
                    begin
                        next_tx_valid = 1'b0;
                        next_state = after;
                        if (after == rakl_pkg::RAKL_IDLE)
                        begin
                            next_done = 1'b1;
                            next_rec_count = 16'h0000;
                        end
                    end
                end
                default:
                begin
                    // Dead line: reception stops until reset
                    next_state = rakl_pkg::RAKL_DEAD; // RULE14
                end
            endcase
        end
    end

    // ------------------------------------------------------------------
    // Registers
    // ------------------------------------------------------------------
    always_ff @(posedge clk)
    begin
        if (!rstn)
        begin
            state <= rakl_pkg::RAKL_IDLE;
            after <= rakl_pkg::RAKL_IDLE;
            dig_cnt <= 7'h00;
            hdr <= 32'h0;
            sum_field <= 16'h0000;
            byte_hi <= 4'h0;
            byte_idx <= 8'h00;
            addr_pending <= 1'b0;
            addr_ok <= 1'b0;
            err <= `RAKL_NO_ERR;
            rec_count <= 16'h0000;
            tmo <= 10'h000;
            miss <= 1'b0;
            tx_char <= 8'h00;
            tx_valid <= 1'b0;
            mem_we <= 1'b0;
            mem_addr <= 16'h0000;
            mem_data <= 8'h00;
            last_nak <= `RAKL_NO_ERR;
            transfer_done <= 1'b0;
            operator_alert <= 1'b0;
        end
        else
        begin
            state <= next_state;
            after <= next_after;
            dig_cnt <= next_dig_cnt;
            hdr <= next_hdr;
            sum_field <= next_sum_field;
            byte_hi <= next_byte_hi;
            byte_idx <= next_byte_idx;
            addr_pending <= next_addr_pending;
            addr_ok <= next_addr_ok;
            err <= next_err;
            rec_count <= next_rec_count;
            tmo <= next_tmo;
            miss <= next_miss;
            tx_char <= next_tx_char;
            tx_valid <= next_tx_valid;
            mem_we <= next_mem_we;
            mem_addr <= next_mem_addr;
            mem_data <= next_mem_data;
            last_nak <= next_last_nak;
            transfer_done <= next_done;
            operator_alert <= next_alert;
        end
    end

    assign record_byte_count = hdr[31:24];
    assign record_start_address = hdr[23:8];
    assign address_checksum = hdr[7:0];
    assign record_checksum = sum_field;
    assign record_total = rec_count;
    assign line_dead = (state == rakl_pkg::RAKL_DEAD); // RULE14

endmodule : rakl_receiver

// File: core/rakl_tick.sv
`timescale 1ns/1ns

module rakl_tick #(
    parameter int TICK_CYCLES = 3333333
) (
    input wire logic clk,
    input wire logic rstn,
    output logic tick
);

    generate
        if (TICK_CYCLES < 1)
        begin : g_bad
            $error("rakl_tick: TICK_CYCLES must be at least 1");
        end
    endgenerate

    logic [31:0] cnt;
    logic [31:0] next_cnt;
    logic next_tick;

    always_comb
    begin
        if (cnt == 32'(TICK_CYCLES - 1))
        begin
            next_cnt = 32'h0;
            next_tick = 1'b1;
        end
        else
        begin
            next_cnt = cnt + 32'h1;
            next_tick = 1'b0;
        end
    end

    always_ff @(posedge clk)
    begin
        if (!rstn)
        begin
            cnt <= 32'h0;
            tick <= 1'b0;
        end
        else
        begin
            cnt <= next_cnt;
            tick <= next_tick;
        end
    end

endmodule : rakl_tick

// File: verif/rakl_receiver_chk.sv
`timescale 1ns/1ns

// --------------------------------------------------------------------
// Answer channel and dead-line checks
// --------------------------------------------------------------------
module rakl_receiver_chk (
    input wire logic clk,
    input wire logic rstn,
    input wire logic [7:0] rx_char,
    input wire logic rx_valid,
    input wire logic tx_ready,
    input wire logic [7:0] tx_char,
    input wire logic tx_valid,
    input wire logic mem_we,
    input wire logic [7:0] record_byte_count,
    input wire logic transfer_done,
    input wire logic line_dead,
    input wire logic operator_alert
);
    default clocking cb @(posedge clk);
    endclocking
    default disable iff (!rstn);

    property p_code;
        $rose(tx_valid) |-> tx_char inside {8'h2A, 8'h55, 8'h30, 8'h54,
            8'h41, 8'h43, 8'h4C};
    endproperty
    a_code: assert property (p_code) else $error("bad code");
    property p_after_cr;
        $rose(tx_valid) && tx_char != 8'h54 |->
            $past(rx_valid) && ($past(rx_char) & 8'h7F) == 8'h0D;
    endproperty
    a_after_cr: assert property (p_after_cr) else $error("early");
    property p_hold;
        tx_valid && !tx_ready |=> tx_valid && $stable(tx_char);
    endproperty
    a_hold: assert property (p_hold) else $error("answer lost");
    property p_drop;
        tx_valid && tx_ready |=> !tx_valid;
    endproperty
    a_drop: assert property (p_drop) else $error("answer twice");
    property p_alert;
        operator_alert |-> ##[0:1] line_dead;
    endproperty
    a_alert: assert property (p_alert) else $error("alert alone");
    property p_dead_stay;
        line_dead |=> line_dead;
    endproperty
    a_dead_stay: assert property (p_dead_stay) else $error("revived");
    property p_dead_quiet;
        line_dead |=> !tx_valid && !mem_we;
    endproperty
    a_dead_quiet: assert property (p_dead_quiet) else $error("dead");
    property p_done;
        transfer_done |-> $past(tx_valid && tx_ready && tx_char == 8'h2A);
    endproperty
    a_done: assert property (p_done) else $error("done w/o ack");
    property p_count_nak;
        $rose(tx_valid) && tx_char == 8'h30 |-> record_byte_count == 8'h00;
    endproperty
    a_count_nak: assert property (p_count_nak) else $error("cnt");
endmodule : rakl_receiver_chk

bind rakl_receiver rakl_receiver_chk u_rakl_receiver_chk (.clk(clk),
    .rstn(rstn), .rx_char(rx_char), .rx_valid(rx_valid),
    .tx_ready(tx_ready), .tx_char(tx_char), .tx_valid(tx_valid),
    .mem_we(mem_we), .record_byte_count(record_byte_count),
    .transfer_done(transfer_done), .line_dead(line_dead),
    .operator_alert(operator_alert));

// File: verif/rakl_sender.sv
`timescale 1ns/1ns

// --------------------------------------------------------------------
// Far-end sender
// --------------------------------------------------------------------
module rakl_sender (
    input wire logic clk,
    input wire logic [7:0] tx_char,
    input wire logic tx_valid,
    output logic [7:0] rx_char,
    output logic rx_valid,
    output logic tx_ready
);
    initial
    begin
        rx_char = 8'h00;
        rx_valid = 1'b0;
        tx_ready = 1'b0;
    end

    // One idle cycle between characters, bit 7 is noise; released line shows inverted data
    task automatic send_rec(input string s);
        byte b;
        for (int i = 0; i < s.len(); i++)
        begin
            b = s[i];
            @(posedge clk);
            #1;
            rx_char = {1'($urandom), b[6:0]};
            rx_valid = 1'b1;
            @(posedge clk);
            #1;
            rx_valid = 1'b0;
            rx_char = ~rx_char;
        end
    endtask : send_rec

    // Answer taken after a random stall
    task automatic get_ans(input int lim, output logic [7:0] c,
            output int n);
        n = 0;
        c = 8'h00;
        while (tx_valid !== 1'b1 && n < lim)
        begin
            @(posedge clk);
            #1;
            n++;
        end
        if (n < lim)
        begin
            for (int k = $urandom_range(3); k > 0; k--)
            begin
                @(posedge clk);
                #1;
            end
            c = tx_char;
            tx_ready = 1'b1;
            @(posedge clk);
            #1;
            tx_ready = 1'b0;
        end
    endtask : get_ans
endmodule : rakl_sender

// File: verif/test_record_ack_link_protocol.sv
`timescale 1ns/1ns

// --------------------------------------------------------------------
// Receiver bench
// --------------------------------------------------------------------
module test_record_ack_link_protocol;
    localparam int TK = 20;
    logic clk, rstn, addr_ok, rec_ok, rx_valid, tx_ready, tx_valid, mem_we;
    logic [7:0] rx_char, tx_char, record_byte_count, address_checksum;
    logic [7:0] mem_data, last_nak;
    logic [15:0] mem_addr, record_start_address, record_checksum;
    logic [15:0] record_total;
    logic transfer_done, line_dead, operator_alert;
    int err_count = 0;
    int n_compared = 0;
    int n_recs = 0;
    int exp_wr[$];

    rakl_receiver #(.TICK_CYCLES(TK)) u_rakl_receiver (.clk(clk),
        .rstn(rstn), .rx_char(rx_char), .rx_valid(rx_valid),
        .addr_check_ok(addr_ok), .rec_check_ok(rec_ok),
        .tx_ready(tx_ready), .tx_char(tx_char), .tx_valid(tx_valid),
        .mem_we(mem_we), .mem_addr(mem_addr), .mem_data(mem_data),
        .record_byte_count(record_byte_count),
        .record_start_address(record_start_address),
        .address_checksum(address_checksum),
        .record_checksum(record_checksum), .record_total(record_total),
        .last_nak(last_nak), .transfer_done(transfer_done),
        .line_dead(line_dead), .operator_alert(operator_alert));
    rakl_sender u_rakl_sender (.clk(clk), .tx_char(tx_char),
        .tx_valid(tx_valid), .rx_char(rx_char), .rx_valid(rx_valid),
        .tx_ready(tx_ready));

    initial
    begin
        clk = 1'b0;
        forever #10 clk = ~clk;
    end

    task automatic check(input string what, input logic [23:0] seen,
            input logic [23:0] exp);
        n_compared++;
        if (seen !== exp)
        begin
            err_count++;
            $display("wrong value %s: expected %h, seen %h", what, exp, seen);
        end
    endtask : check

    task automatic finish_test();
        if (err_count == 0 && n_compared > 0)
            $display("Testbench passed");
        else
            $display("Testbench failed");
        $finish;
    endtask : finish_test

    always @(posedge clk)
        if (mem_we === 1'b1)
            check("write", {mem_addr, mem_data}, exp_wr.size() > 0 ?
                24'(exp_wr.pop_front()) : 24'bx);

    // Model: first failing verdict decides the answer code
    task automatic rec(input int cnt, input int adr, input bit a_ok,
            input bit r_ok);
        string s;
        logic [7:0] c;
        logic [7:0] exp;
        int d;
        int n;
        s = $sformatf(";%02X%04X00", cnt, adr);
        for (int i = 0; i < cnt; i++)
        begin
            d = $urandom_range(255);
            s = {s, $sformatf("%02X", d)};
            if (a_ok)
                exp_wr.push_back(((adr + i) % 65536) * 256 + d);
        end
        exp = !a_ok ? 8'h41 : !r_ok ? 8'h43 :
            (cnt == 0 && adr != n_recs) ? 8'h30 : 8'h2A;
        addr_ok = a_ok;
        rec_ok = r_ok;
        u_rakl_sender.send_rec({s, "0000\015"});
        u_rakl_sender.get_ans(15 * TK, c, n);
        check("answered", 24'(n < 15 * TK), 24'h1);
        if (n >= 15 * TK)
            finish_test();
        check("answer", 24'(c), 24'(exp));
        if (exp == 8'h2A)
            n_recs = cnt == 0 ? 0 : n_recs + 1;
        check("total", 24'(record_total), 24'(n_recs));
        check("done", 24'(transfer_done), 24'(cnt == 0 && exp == 8'h2A));
        check("left", 24'(exp_wr.size()), 24'h0);
    endtask : rec

    initial
    begin
        logic [7:0] c;
        int n;
        void'($urandom(72052));
        rstn = 1'b0;
        addr_ok = 1'b0;
        rec_ok = 1'b0;
        repeat (4) @(posedge clk);
        #1;
        rstn = 1'b1;
        u_rakl_sender.send_rec("go\015\012");
        rec(2, 16'h0100, 1, 1);
        rec(1, 16'h0200, 1, 0);
        rec(1, 16'h0200, 1, 1);
        rec(3, 16'h0300, 0, 1);
        rec(32, 16'hFFF0, 1, 1);
        repeat (4) rec($urandom_range(1, 4), $urandom_range(16'hFFFF),
            $urandom_range(3) != 0, $urandom_range(3) != 0);
        rec(0, n_recs + 1, 1, 1);
        rec(0, n_recs, 1, 1);
        rec(1, 16'h0000, 1, 1);
        u_rakl_sender.get_ans(227 * TK, c, n);
        check("timeout code", 24'(c), 24'h54);
        check("timeout wait", 24'(n >= 225 * TK), 24'h1);
        n = 0;
        while (line_dead !== 1'b1 && n < 227 * TK)
        begin
            @(posedge clk);
            #1;
            n++;
        end
        check("dead", 24'(line_dead), 24'h1);
        check("dead code", 24'(last_nak), 24'h54);
        if (n >= 227 * TK)
            finish_test();
        u_rakl_sender.send_rec(";00000000000000\015");
        u_rakl_sender.get_ans(15 * TK, c, n);
        check("dead silent", 24'(n), 24'(15 * TK));
        rstn = 1'b0;
        repeat (2) @(posedge clk);
        #1;
        check("reset", {tx_valid, line_dead, record_total}, 24'h0);
        rstn = 1'b1;
        finish_test();
    end
endmodule : test_record_ack_link_protocol
